// ==== nsq_requant_ctrl.sv ====
// Noise shaping requantizer with serial port, power and stabilizer control
`timescale 1ns/100ps
`include "nsq_params.svh"
module nsq_requant_ctrl import nsq_pkg::*; #(
  parameter int IN_W = 16,
  parameter int OUT_W = 11,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic spi_csb_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdio_i,
  output logic spi_sdio_o,
  output logic spi_sdio_oe_n_o,
  input wire logic power_down_request_i,
  input wire logic [2:0] clk_div_ratio_i,
  input wire logic clk_freq_change_i,
  input wire logic clk_below_min_i,
  input wire logic smp_valid_i,
  output logic smp_ready_o,
  input wire logic [IN_W-1:0] smp_a_i,
  input wire logic [IN_W-1:0] smp_b_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [OUT_W-1:0] out_a_o,
  output logic [OUT_W-1:0] out_b_o,
  output logic ref_en_o,
  output logic ref_buf_en_o,
  output logic bias_en_o,
  output logic int_clk_en_o,
  output logic duty_cycle_stabilizer_retime_o,
  output logic duty_cycle_stabilizer_bypass_o,
  output logic [6:0] band_lower_o,
  output logic [6:0] band_center_o,
  output logic [6:0] band_upper_o
);
  localparam int SH = IN_W - OUT_W;
  localparam int VW = IN_W + 3;
  localparam int EW = SH + 2;
  localparam logic [11:0] RELOCK_LAST = 12'(`NSQ_RELOCK_CYC - 1);

  generate
    if (SH < 2 || OUT_W < 4) begin : g_bad_width
      $error("Input must be at least two bits wider than the output");
    end
  endgenerate

  //------------------------------------------------------------
  // Pin synchronisers
  //------------------------------------------------------------
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic sclk_d_r;
  logic csb_s;
  logic sclk_s;
  logic sdi_s;
  logic pd_pin_s;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pin_s1_r <= 4'h1;
      pin_s2_r <= 4'h1;
      sclk_d_r <= 1'b0;
    end else if (ce_i) begin
      pin_s1_r <= {power_down_request_i, spi_sdio_i, spi_sclk_i, spi_csb_i};
      pin_s2_r <= pin_s1_r;
      sclk_d_r <= pin_s2_r[1];
    end
  end

  assign csb_s = pin_s2_r[0];
  assign sclk_s = pin_s2_r[1];
  assign sdi_s = pin_s2_r[2];
  assign pd_pin_s = pin_s2_r[3];

  //------------------------------------------------------------
  // Serial port and registers
  //------------------------------------------------------------
  logic [4:0] bit_cnt_r;
  logic [4:0] bit_cnt_nxt;
  logic [14:0] shift_r;
  logic [14:0] shift_nxt;
  logic [7:0] rd_sh_r;
  logic [7:0] rd_sh_nxt;
  logic oe_n_r;
  logic oe_n_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] tune_r;
  logic [7:0] tune_nxt;
  logic [7:0] pwr_r;
  logic [7:0] pwr_nxt;
  logic [7:0] dcs_r;
  logic [7:0] dcs_nxt;
  logic [7:0] status;
  logic sclk_rise;

  function automatic logic [7:0] reg_read(input logic [6:0] addr, input logic [7:0] c, input logic [7:0] t,
                                          input logic [7:0] p, input logic [7:0] d, input logic [7:0] s);
    case (addr)
      `NSQ_ADDR_CTRL: reg_read = c;
      `NSQ_ADDR_TUNE: reg_read = t;
      `NSQ_ADDR_PWR: reg_read = p;
      `NSQ_ADDR_DCS: reg_read = d;
      `NSQ_ADDR_STAT: reg_read = s;
      default: reg_read = 8'h00;
    endcase
  endfunction

  always_comb begin
    sclk_rise = sclk_s && !sclk_d_r && !csb_s;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    rd_sh_nxt = rd_sh_r;
    oe_n_nxt = oe_n_r;
    ctrl_nxt = ctrl_r;
    tune_nxt = tune_r;
    pwr_nxt = pwr_r;
    dcs_nxt = dcs_r;
    if (csb_s) begin
      bit_cnt_nxt = 5'h00;
      oe_n_nxt = 1'b1;
    end else if (sclk_rise && bit_cnt_r != `NSQ_FRAME_BITS) begin
      bit_cnt_nxt = bit_cnt_r + 5'h01;
      shift_nxt = {shift_r[13:0], sdi_s};
      rd_sh_nxt = {rd_sh_r[6:0], 1'b0};
      if (bit_cnt_r == `NSQ_INSTR_LAST && shift_r[6]) begin
        rd_sh_nxt = reg_read({shift_r[5:0], sdi_s}, ctrl_r, tune_r, pwr_r, dcs_r, status);
        oe_n_nxt = 1'b0;
      end
      if (bit_cnt_r == `NSQ_FRAME_LAST && !shift_r[14]) begin
        case (shift_r[13:7])
          `NSQ_ADDR_CTRL: ctrl_nxt = {5'h00, shift_r[1:0], sdi_s};
          `NSQ_ADDR_TUNE: tune_nxt = {2'h0, shift_r[4:0], sdi_s};
          `NSQ_ADDR_PWR: pwr_nxt = {6'h00, shift_r[0], sdi_s};
          `NSQ_ADDR_DCS: dcs_nxt = {7'h00, sdi_s};
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      bit_cnt_r <= 5'h00;
      shift_r <= '0;
      rd_sh_r <= 8'h00;
      oe_n_r <= 1'b1;
      ctrl_r <= `NSQ_CTRL_RST;
      tune_r <= `NSQ_TUNE_RST;
      pwr_r <= `NSQ_PWR_RST;
      dcs_r <= `NSQ_DCS_RST;
    end else if (ce_i) begin
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      rd_sh_r <= rd_sh_nxt;
      oe_n_r <= oe_n_nxt;
      ctrl_r <= ctrl_nxt;
      tune_r <= tune_nxt;
      pwr_r <= pwr_nxt;
      dcs_r <= dcs_nxt;
    end
  end

  assign spi_sdio_o = rd_sh_r[7];
  assign spi_sdio_oe_n_o = oe_n_r;

  //------------------------------------------------------------
  // Power state
  //------------------------------------------------------------
  nsq_pwr_e pwr_st_r;
  nsq_pwr_e pwr_st_nxt;

  always_comb begin
    if (pd_pin_s || pwr_r[`NSQ_PWR_PD_BIT]) begin
      pwr_st_nxt = NSQ_PWR_DOWN;
    end else if (pwr_r[`NSQ_PWR_SB_BIT]) begin
      pwr_st_nxt = NSQ_PWR_STANDBY;
    end else begin
      pwr_st_nxt = NSQ_PWR_ON;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pwr_st_r <= NSQ_PWR_ON;
    end else if (ce_i) begin
      pwr_st_r <= pwr_st_nxt;
    end
  end

  always_comb begin
    case (pwr_st_r)
      NSQ_PWR_ON: {ref_en_o, ref_buf_en_o, bias_en_o, int_clk_en_o} = 4'hf;
      NSQ_PWR_STANDBY: {ref_en_o, ref_buf_en_o, bias_en_o, int_clk_en_o} = 4'hc;
      NSQ_PWR_DOWN: {ref_en_o, ref_buf_en_o, bias_en_o, int_clk_en_o} = 4'h0;
      default: {ref_en_o, ref_buf_en_o, bias_en_o, int_clk_en_o} = 4'h0;
    endcase
  end

  //------------------------------------------------------------
  // Duty cycle stabilizer
  //------------------------------------------------------------
  nsq_dcs_e dcs_st_r;
  nsq_dcs_e dcs_st_nxt;
  logic [11:0] lock_cnt_r;
  logic [11:0] lock_cnt_nxt;
  logic dcs_want;

  always_comb begin
    dcs_want = (dcs_r[`NSQ_DCS_EN_BIT] || clk_div_ratio_i != 3'h0)
               && !clk_below_min_i && int_clk_en_o;
    dcs_st_nxt = dcs_st_r;
    lock_cnt_nxt = lock_cnt_r;
    case (dcs_st_r)
      NSQ_DCS_OFF: begin
        if (dcs_want) begin
          dcs_st_nxt = NSQ_DCS_RELOCK;
          lock_cnt_nxt = 12'h000;
        end
      end
      NSQ_DCS_RELOCK: begin
        if (!dcs_want) begin
          dcs_st_nxt = NSQ_DCS_OFF;
        end else if (clk_freq_change_i) begin
          lock_cnt_nxt = 12'h000;
        end else if (lock_cnt_r == RELOCK_LAST) begin
          dcs_st_nxt = NSQ_DCS_LOCKED;
        end else begin
          lock_cnt_nxt = lock_cnt_r + 12'h001;
        end
      end
      NSQ_DCS_LOCKED: begin
        if (!dcs_want) begin
          dcs_st_nxt = NSQ_DCS_OFF;
        end else if (clk_freq_change_i) begin
          dcs_st_nxt = NSQ_DCS_RELOCK;
          lock_cnt_nxt = 12'h000;
        end
      end
      default: dcs_st_nxt = NSQ_DCS_OFF;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dcs_st_r <= NSQ_DCS_OFF;
      lock_cnt_r <= 12'h000;
    end else if (ce_i) begin
      dcs_st_r <= dcs_st_nxt;
      lock_cnt_r <= lock_cnt_nxt;
    end
  end

  assign duty_cycle_stabilizer_retime_o = (dcs_st_r == NSQ_DCS_LOCKED);
  assign duty_cycle_stabilizer_bypass_o = (dcs_st_r != NSQ_DCS_LOCKED);
  assign status = {4'h0, dcs_st_r == NSQ_DCS_RELOCK, duty_cycle_stabilizer_retime_o,
                   pwr_st_r == NSQ_PWR_STANDBY, pwr_st_r == NSQ_PWR_DOWN};

  //------------------------------------------------------------
  // Band placement
  //------------------------------------------------------------
  logic [5:0] tw_eff;
  logic bw_wide;
  logic signed [12:0] notch_k;

  function automatic logic signed [12:0] cos2_coef(input logic [6:0] c);
    logic [6:0] q;
    logic [21:0] sq;
    logic [12:0] mag;
    q = (c > `NSQ_QUARTER_STEPS) ? `NSQ_HALF_STEPS - c : c;
    sq = 22'(22'(q) * 22'(q)) * `NSQ_COS_K;
    mag = `NSQ_COS_ONE - 13'(sq >> 10);
    cos2_coef = (c > `NSQ_QUARTER_STEPS) ? -$signed(mag) : $signed(mag);
  endfunction

  always_comb begin
    tw_eff = (tune_r[5:0] > `NSQ_TW_MAX) ? `NSQ_TW_MAX : tune_r[5:0];
    bw_wide = ctrl_r[`NSQ_CTRL_BW_BIT];
    band_lower_o = {1'b0, tw_eff};
    band_center_o = {1'b0, tw_eff} + (bw_wide ? `NSQ_CTR_WIDE : `NSQ_CTR_NARROW);
    band_upper_o = {1'b0, tw_eff} + (bw_wide ? `NSQ_UP_WIDE : `NSQ_UP_NARROW);
    notch_k = cos2_coef(band_center_o);
  end

  //------------------------------------------------------------
  // Requantizer datapath
  //------------------------------------------------------------
  logic fifo_in_ready;
  logic take;
  logic [2*OUT_W-1:0] fifo_in_data;
  logic [2*OUT_W-1:0] fifo_out_data;

  assign smp_ready_o = fifo_in_ready && int_clk_en_o;
  assign take = smp_valid_i && smp_ready_o;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic signed [IN_W-1:0] x;
      logic signed [VW-1:0] s;
      logic signed [VW-1:0] v;
      logic signed [VW+13:0] fb;
      logic signed [VW-1:0] yq;
      logic signed [VW-1:0] e;
      logic signed [OUT_W-1:0] y;
      logic signed [EW-1:0] e1_r;
      logic signed [EW-1:0] e1_nxt;
      logic signed [EW-1:0] e2_r;
      logic signed [EW-1:0] e2_nxt;
      logic en;

      always_comb begin
        x = (ch == 0) ? smp_a_i : smp_b_i;
        en = ctrl_r[ch];
        s = VW'(($signed({{13{x[IN_W-1]}}, x}) * $signed({20'h00000, `NSQ_GAIN_Q8})) >>> 8);
        fb = $signed(notch_k) * $signed(e1_r);
        v = en ? s - VW'(fb >>> 10) + VW'(e2_r) : VW'(x);
        yq = (v + VW'(1 << (SH - 1))) >>> SH;
        if (yq > VW'((1 << (OUT_W - 1)) - 1)) begin
          yq = VW'((1 << (OUT_W - 1)) - 1);
        end else if (yq < -VW'(1 << (OUT_W - 1))) begin
          yq = -VW'(1 << (OUT_W - 1));
        end
        y = yq[OUT_W-1:0];
        e = (yq <<< SH) - v;
        if (e > VW'((1 << (EW - 1)) - 1)) begin
          e = VW'((1 << (EW - 1)) - 1);
        end else if (e < -VW'(1 << (EW - 1))) begin
          e = -VW'(1 << (EW - 1));
        end
        e1_nxt = e1_r;
        e2_nxt = e2_r;
        if (!en) begin
          e1_nxt = '0;
          e2_nxt = '0;
        end else if (take) begin
          e1_nxt = e[EW-1:0];
          e2_nxt = e1_r;
        end
      end

      always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          e1_r <= '0;
          e2_r <= '0;
        end else if (ce_i) begin
          e1_r <= e1_nxt;
          e2_r <= e2_nxt;
        end
      end

      assign fifo_in_data[ch*OUT_W +: OUT_W] = y;
    end
  endgenerate

  nsq_fifo #(
    .WIDTH(2 * OUT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .in_valid_i(smp_valid_i && int_clk_en_o),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(fifo_out_data)
  );

  assign out_a_o = fifo_out_data[OUT_W-1:0];
  assign out_b_o = fifo_out_data[2*OUT_W-1:OUT_W];
endmodule

// ==== nsq_params.svh ====
// Constants for the noise shaping requantizer controller
`ifndef NSQ_PARAMS_SVH
`define NSQ_PARAMS_SVH

// Register addresses
`define NSQ_ADDR_CTRL 7'h3c
`define NSQ_ADDR_TUNE 7'h3e
`define NSQ_ADDR_PWR 7'h40
`define NSQ_ADDR_DCS 7'h41
`define NSQ_ADDR_STAT 7'h42

// Field positions
`define NSQ_CTRL_EN0_BIT 0
`define NSQ_CTRL_EN1_BIT 1
`define NSQ_CTRL_BW_BIT 2
`define NSQ_PWR_PD_BIT 0
`define NSQ_PWR_SB_BIT 1
`define NSQ_DCS_EN_BIT 0

// Reset values
`define NSQ_CTRL_RST 8'h00
`define NSQ_TUNE_RST 8'h00
`define NSQ_PWR_RST 8'h00
`define NSQ_DCS_RST 8'h01

// Band placement, in steps of 0.5% of the sample rate
`define NSQ_TW_MAX 6'h38
`define NSQ_CTR_NARROW 7'h16
`define NSQ_UP_NARROW 7'h2c
`define NSQ_CTR_WIDE 7'h21
`define NSQ_UP_WIDE 7'h42
`define NSQ_HALF_STEPS 7'h64
`define NSQ_QUARTER_STEPS 7'h32
`define NSQ_COS_K 22'h00347
`define NSQ_COS_ONE 13'h0800

// Output gain of 0.6 dB loss in Q8
`define NSQ_GAIN_Q8 10'h0ef

// Serial frame
`define NSQ_FRAME_BITS 5'h10
`define NSQ_INSTR_LAST 5'h07
`define NSQ_FRAME_LAST 5'h0f

// Timing
`define NSQ_CLK_PERIOD_PS 10000
`define NSQ_RELOCK_NS 1500
`define NSQ_RELOCK_CYC ((`NSQ_RELOCK_NS * 1000 + `NSQ_CLK_PERIOD_PS - 1) / `NSQ_CLK_PERIOD_PS)

`endif

// ==== nsq_pkg.sv ====
// Types for the noise shaping requantizer controller
package nsq_pkg;

  typedef enum logic [1:0] {
    NSQ_PWR_ON,
    NSQ_PWR_STANDBY,
    NSQ_PWR_DOWN
  } nsq_pwr_e;

  typedef enum logic [1:0] {
    NSQ_DCS_OFF,
    NSQ_DCS_RELOCK,
    NSQ_DCS_LOCKED
  } nsq_dcs_e;

endpackage

// ==== nsq_fifo.sv ====
// Sample FIFO with valid/ready on both sides
`timescale 1ns/100ps
module nsq_fifo import nsq_pkg::*; #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("FIFO depth must be a power of two of at least two");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] wr_ptr_nxt;
  logic [AW:0] rd_ptr_r;
  logic [AW:0] rd_ptr_nxt;
  logic full;
  logic empty;
  logic push;
  logic pop;

  //------------------------------------------------------------
  // Pointers
  //------------------------------------------------------------
  always_comb begin
    full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    empty = (wr_ptr_r == rd_ptr_r);
    in_ready_o = !full;
    out_valid_o = !empty;
    push = in_valid_i && !full;
    pop = out_ready_i && !empty;
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else if (ce_i) begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (ce_i && push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

  assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];
endmodule

// ==== nsq_requant_ctrl_sva.sv ====
// Port checker for the requantizer controller
`timescale 1ns/100ps
module nsq_requant_ctrl_sva import nsq_pkg::*; #(
  parameter int OUT_W = 11
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic power_down_request_i,
  input wire logic clk_freq_change_i,
  input wire logic clk_below_min_i,
  input wire logic smp_valid_i,
  input wire logic smp_ready_o,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [OUT_W-1:0] out_a_o,
  input wire logic ref_en_o,
  input wire logic bias_en_o,
  input wire logic int_clk_en_o,
  input wire logic duty_cycle_stabilizer_retime_o,
  input wire logic duty_cycle_stabilizer_bypass_o,
  input wire logic [6:0] band_lower_o,
  input wire logic [6:0] band_center_o,
  input wire logic [6:0] band_upper_o
);
  // ------
  // Checks
  // ------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic [8:0] low_cnt_r;
  logic [8:0] low_cnt_nxt;
  always_comb begin
    low_cnt_nxt = (low_cnt_r == 9'h1ff) ? low_cnt_r : low_cnt_r + 9'h001;
    if (duty_cycle_stabilizer_retime_o) begin
      low_cnt_nxt = 9'h000;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    low_cnt_r <= sys_rst_i ? 9'h000 : low_cnt_nxt;
  end
  sequence s_pin_held;
    (power_down_request_i && ce_i) [*5];
  endsequence
  sequence s_sink_stall;
    out_valid_o && !out_ready_i;
  endsequence
  a_pin_down: assert property (s_pin_held |-> !ref_en_o && !bias_en_o && !int_clk_en_o)
    else $error("pin did not power down");
  a_down_ready: assert property (!int_clk_en_o |-> !smp_ready_o)
    else $error("samples taken without clock");
  a_bypass_inv: assert property (duty_cycle_stabilizer_bypass_o != duty_cycle_stabilizer_retime_o)
    else $error("bypass and retime agree");
  a_lock_wait: assert property ($rose(duty_cycle_stabilizer_retime_o) |-> low_cnt_r >= 9'h096)
    else $error("relock too early");
  a_freq_restart: assert property (clk_freq_change_i |=> duty_cycle_stabilizer_bypass_o [*8])
    else $error("rate change not bypassed");
  a_slow_bypass: assert property (clk_below_min_i |=> duty_cycle_stabilizer_bypass_o)
    else $error("slow clock not bypassed");
  a_band_span: assert property ((band_upper_o == band_lower_o + 7'h2c && band_center_o == band_lower_o + 7'h16) ||
    (band_upper_o == band_lower_o + 7'h42 && band_center_o == band_lower_o + 7'h21))
    else $error("band edges inconsistent");
  a_tune_clamp: assert property (band_lower_o <= 7'h38)
    else $error("band lower edge too high");
  a_fifo_hold: assert property (s_sink_stall |=> out_valid_o && $stable(out_a_o))
    else $error("output dropped under stall");
  a_push_valid: assert property (smp_valid_i && smp_ready_o |=> out_valid_o)
    else $error("pushed sample not offered");
endmodule

bind nsq_requant_ctrl nsq_requant_ctrl_sva #(.OUT_W(OUT_W)) chk_u (.*);

// ==== nsq_partner.sv ====
// Sample source and output sink at the block's far side
`timescale 1ns/100ps
module nsq_partner #(
  parameter int IN_W = 16,
  parameter int OUT_W = 11
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic stall_i,
  input wire logic [15:0] quota_i,
  input wire logic [IN_W-1:0] a_val_i,
  input wire logic [IN_W-1:0] b_val_i,
  output logic smp_valid_o,
  input wire logic smp_ready_i,
  output logic [IN_W-1:0] smp_a_o,
  output logic [IN_W-1:0] smp_b_o,
  input wire logic out_valid_i,
  output logic out_ready_o,
  input wire logic [OUT_W-1:0] out_a_i,
  input wire logic [OUT_W-1:0] out_b_i,
  output logic [15:0] pushes_o,
  output logic [15:0] pops_o,
  output logic [OUT_W-1:0] got_a_o,
  output logic [OUT_W-1:0] got_b_o
);
  initial begin
    smp_valid_o = 1'b0;
    smp_a_o = '0;
    smp_b_o = '0;
    out_ready_o = 1'b0;
  end
  // Held until taken; idle data toggles
  always @(negedge clk_sys_i) begin
    smp_valid_o <= pushes_o < quota_i;
    smp_a_o <= (pushes_o < quota_i) ? a_val_i : ~smp_a_o;
    smp_b_o <= (pushes_o < quota_i) ? b_val_i : ~smp_b_o;
    out_ready_o <= !stall_i;
  end
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pushes_o <= 16'h0000;
      pops_o <= 16'h0000;
    end else begin
      if (smp_valid_o && smp_ready_i) begin
        pushes_o <= pushes_o + 16'h0001;
      end
      if (out_valid_i && out_ready_o) begin
        pops_o <= pops_o + 16'h0001;
        got_a_o <= out_a_i;
        got_b_o <= out_b_i;
      end
    end
  end
endmodule

// ==== test_noise_shaping_requantizer_ctrl.sv ====
// Self-checking bench for the requantizer controller
`timescale 1ns/100ps
module test_noise_shaping_requantizer_ctrl import nsq_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic spi_csb_i = 1'b1;
  logic spi_sclk_i = 1'b0;
  logic sdio_tb = 1'b0;
  logic power_down_request_i = 1'b0;
  logic [2:0] clk_div_ratio_i = 3'h0;
  logic clk_freq_change_i = 1'b0;
  logic clk_below_min_i = 1'b0;
  logic stall = 1'b0;
  logic [15:0] quota = 16'h0000;
  logic [15:0] a_val = 16'h0000;
  logic [15:0] b_val = 16'h0000;
  logic smp_valid_i, smp_ready_o, out_valid_o, out_ready_i, spi_sdio_o, spi_sdio_oe_n_o;
  logic [15:0] smp_a_i, smp_b_i, pushes, pops;
  logic [10:0] out_a_o, out_b_o, got_a, got_b;
  logic ref_en_o, ref_buf_en_o, bias_en_o, int_clk_en_o;
  logic duty_cycle_stabilizer_retime_o, duty_cycle_stabilizer_bypass_o;
  logic [6:0] band_lower_o, band_center_o, band_upper_o;
  wire spi_sdio_i = spi_sdio_oe_n_o ? sdio_tb : spi_sdio_o;
  wire [3:0] pwr = {ref_en_o, ref_buf_en_o, bias_en_o, int_clk_en_o};
  int errors = 0;
  int samples_checked = 0;

  nsq_requant_ctrl dut_u (.*);
  nsq_partner part_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .stall_i(stall), .quota_i(quota),
    .a_val_i(a_val), .b_val_i(b_val), .smp_valid_o(smp_valid_i), .smp_ready_i(smp_ready_o),
    .smp_a_o(smp_a_i), .smp_b_o(smp_b_i), .out_valid_i(out_valid_o), .out_ready_o(out_ready_i),
    .out_a_i(out_a_o), .out_b_i(out_b_o), .pushes_o(pushes), .pops_o(pops), .got_a_o(got_a), .got_b_o(got_b));

  // -----------
  // Shared tasks
  // -----------
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic spi(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, d};
    q = 8'h00;
    cyc(1);
    spi_csb_i = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdio_tb = f[i];
      cyc(5);
      spi_sclk_i = 1'b1;
      cyc(5);
      spi_sclk_i = 1'b0;
      if (i > 0 && i < 9) q[i-1] = spi_sdio_i;
    end
    cyc(5);
    spi_csb_i = 1'b1;
    cyc(6);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi(1'b0, a, d, q);
  endtask
  task automatic rdchk(input string n, input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    spi(1'b1, a, 8'h00, q);
    chk(n, {8'h00, q}, {8'h00, e});
  endtask

  // ---------
  // Scenarios
  // ---------
  task automatic t_reset;
    chk("power enables", pwr, 4'hf);
    chk("bypass", duty_cycle_stabilizer_bypass_o, 1'b1);
    chk("out valid", out_valid_o, 1'b0);
    rdchk("control", 7'h3c, 8'h00);
    rdchk("stabilizer", 7'h41, 8'h01);
    rdchk("unmapped", 7'h10, 8'h00);
  endtask
  task automatic t_band;
    logic [7:0] tw [6] = '{8'h0d, 8'h05, 8'h29, 8'h1b, 8'h3f, 8'h39};
    logic [6:0] lo;
    for (int i = 0; i < 6; i++) begin
      wr(7'h3c, {5'h00, i[0], 2'b00});
      wr(7'h3e, tw[i]);
      lo = (tw[i] > 8'h38) ? 7'h38 : tw[i][6:0];
      chk("band lower", band_lower_o, lo);
      chk("band center", band_center_o, lo + (i[0] ? 7'h21 : 7'h16));
      chk("band upper", band_upper_o, lo + (i[0] ? 7'h42 : 7'h2c));
    end
    rdchk("tuning", 7'h3e, 8'h39);
  endtask
  task automatic t_power;
    ce_i = 1'b0;
    power_down_request_i = 1'b1;
    cyc(6);
    chk("frozen", pwr, 4'hf);
    ce_i = 1'b1;
    cyc(6);
    chk("pin down", pwr, 4'h0);
    chk("ready in down", smp_ready_o, 1'b0);
    power_down_request_i = 1'b0;
    cyc(6);
    chk("pin wake", pwr, 4'hf);
    wr(7'h40, 8'h02);
    chk("standby", pwr, 4'hc);
    wr(7'h40, 8'h01);
    chk("reg down", pwr, 4'h0);
    wr(7'h40, 8'h00);
    chk("reg wake", pwr, 4'hf);
  endtask
  task automatic t_dcs;
    int n;
    cyc(200);
    chk("locked", duty_cycle_stabilizer_retime_o, 1'b1);
    clk_freq_change_i = 1'b1;
    cyc(1);
    clk_freq_change_i = 1'b0;
    n = 1;
    while (duty_cycle_stabilizer_retime_o !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    chk("relock time", n >= 150 && n <= 152, 1'b1);
    clk_below_min_i = 1'b1;
    cyc(200);
    chk("slow bypass", duty_cycle_stabilizer_bypass_o, 1'b1);
    clk_below_min_i = 1'b0;
    wr(7'h41, 8'h00);
    cyc(200);
    chk("disabled", duty_cycle_stabilizer_bypass_o, 1'b1);
    clk_div_ratio_i = 3'h3;
    cyc(160);
    chk("forced on", duty_cycle_stabilizer_retime_o, 1'b1);
    clk_div_ratio_i = 3'h0;
    wr(7'h41, 8'h01);
  endtask
  task automatic t_data;
    wr(7'h3c, 8'h00);
    a_val = 16'h0400;
    b_val = 16'h7fff;
    stall = 1'b1;
    quota = pushes + 16'h000a;
    cyc(30);
    chk("full refuses", smp_ready_o, 1'b0);
    chk("fifo depth", pushes, quota - 16'h0002);
    stall = 1'b0;
    cyc(30);
    chk("drained", out_valid_o, 1'b0);
    chk("pops", pops, pushes);
    chk("plain a", got_a, 11'h020);
    chk("plain b", got_b, 11'h3ff);
    wr(7'h3c, 8'h01);
    a_val = 16'h7fff;
    quota = pushes + 16'h0010;
    cyc(40);
    chk("scaled a", got_a > 11'h3ab && got_a < 11'h3cc, 1'b1);
    chk("plain b kept", got_b, 11'h3ff);
  endtask

  task automatic complete_run;
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    cyc(4);
    sys_rst_i = 1'b0;
    cyc(4);
    t_reset();
    t_band();
    t_power();
    t_dcs();
    t_data();
    complete_run();
  end
  initial begin
    #300000;
    errors++;
    complete_run();
  end
endmodule
